//--- dv/spi_front_end_monitor.sv
`default_nettype none
// ****************************************
// Port checker for the serial front end
// ****************************************
module spi_front_end_monitor #(
	parameter [19:0] WRITE_CYCLES = 20'h003e8
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Serial pins.
	input wire logic i_spi_sclk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_mosi,
	input wire logic i_hold_n,
	input wire logic i_write_guard_n,
	input wire logic o_spi_miso,
	input wire logic o_spi_miso_oe,
	// Stored bits.
	input wire logic i_nv_lock_stored,
	input wire logic [1:0] i_nv_size_stored,
	input wire logic o_nv_store,
	// Status.
	input wire logic o_status_lock_bit,
	input wire logic [1:0] o_protect_size,
	input wire logic o_write_latch_flag,
	input wire logic o_write_busy_flag,
	input wire logic o_selected,
	input wire logic o_standby,
	input wire logic o_hold_active
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] csn_h;
	logic [7:0] glow_h;
	logic [7:0] hold_h;
	logic [19:0] busy_run;
	// Counts the cycles of the running write cycle.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			busy_run <= 20'h00000;
		end else if (o_write_busy_flag) begin
			busy_run <= busy_run + 20'h00001;
		end else begin
			busy_run <= 20'h00000;
		end
	end
	// Keeps eight samples of pin levels, since the pins are synchronised.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			csn_h <= 8'h00;
			glow_h <= 8'h00;
			hold_h <= 8'h00;
		end else begin
			csn_h <= {csn_h[6:0], i_spi_cs_n};
			glow_h <= {glow_h[6:0], ~i_write_guard_n};
			hold_h <= {hold_h[6:0], ~i_hold_n & ~i_spi_sclk};
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	a_reset_clears: assert property (
		$fell(i_rst) |-> !o_write_latch_flag && !o_write_busy_flag)
		else $error("flags set after reset");
	a_desel_float: assert property (
		i_spi_cs_n [*6] |-> !o_spi_miso_oe)
		else $error("output driven while deselected");
	a_hold_entry: assert property (
		$rose(o_hold_active) |-> hold_h != 8'h00)
		else $error("hold entered without pin low under low clock");
	a_hold_float: assert property (
		o_hold_active [*2] |-> !o_spi_miso_oe)
		else $error("output driven during hold");
	a_busy_latch: assert property (
		$rose(o_write_busy_flag) |-> $past(o_write_latch_flag))
		else $error("write launched without latch");
	a_guard_freeze: assert property (
		o_status_lock_bit && glow_h == 8'hff |=> $stable(o_protect_size))
		else $error("size bits changed while guarded");
	a_sel_edge: assert property (
		$rose(o_selected) |-> csn_h != 8'h00)
		else $error("selected without a select edge");
	a_miso_on_fall: assert property (
		o_spi_miso_oe && $changed(o_spi_miso) |-> !i_spi_sclk)
		else $error("output changed while clock high");
	a_standby_gate: assert property (
		o_standby |-> !$past(o_write_busy_flag) && !$past(o_selected))
		else $error("standby while selected or busy");
	a_busy_length: assert property (
		$fell(o_write_busy_flag) |-> busy_run == WRITE_CYCLES)
		else $error("write cycle length wrong");
	a_store_at_end: assert property (
		o_nv_store |-> $fell(o_write_busy_flag))
		else $error("store pulse outside write cycle end");
	cover property ($rose(o_hold_active));
	cover property ($rose(o_write_busy_flag));
	cover property ($rose(o_nv_store));
endmodule
bind spi_eeprom_bus_front_end spi_front_end_monitor #(
	.WRITE_CYCLES(WRITE_CYCLES)
) chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_spi_sclk(i_spi_sclk),
	.i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi), .i_hold_n(i_hold_n),
	.i_write_guard_n(i_write_guard_n), .o_spi_miso(o_spi_miso),
	.o_spi_miso_oe(o_spi_miso_oe), .i_nv_lock_stored(i_nv_lock_stored),
	.i_nv_size_stored(i_nv_size_stored), .o_nv_store(o_nv_store),
	.o_status_lock_bit(o_status_lock_bit), .o_protect_size(o_protect_size),
	.o_write_latch_flag(o_write_latch_flag),
	.o_write_busy_flag(o_write_busy_flag), .o_selected(o_selected),
	.o_standby(o_standby), .o_hold_active(o_hold_active)
);
`default_nettype wire

//--- dv/spi_master_model.sv
`default_nettype none
// ****************************************
// Bus master driving the serial pins
// ****************************************
module spi_master_model (
	// Clock and data back from the device.
	input wire logic i_clk_sys,
	input wire logic i_miso,
	input wire logic i_miso_oe,
	// Pins toward the device.
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	output logic o_hold_n,
	// Collected read byte.
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cpol = 1'h0;
	logic last = 1'h0;
	logic [7:0] rx = 8'h00;
	// A released line shows the inverse of its last driven level.
	wire logic line = i_miso_oe ? i_miso : ~last;
	initial begin
		{o_sclk, o_cs_n, o_mosi, o_hold_n} = 4'h5;
		{o_rx_valid, o_rx_byte} = 9'h000;
	end
	// Remembers the last driven level of the data line.
	always @(posedge i_clk_sys) begin
		if (i_miso_oe) last <= i_miso;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// Selects with the clock at its idle level.
	task automatic open_frame();
		o_sclk <= cpol;
		tick(4);
		o_cs_n <= 1'h0;
		tick(4);
	endtask
	// Shifts n bits most significant first; rise samples, fall launches.
	// Each phase lasts 62.5 ns, so a bit takes 125 ns.
	task automatic shift(input logic [39:0] d, input int n, input bit lsn);
		for (int i = n - 1; i >= 0; i--) begin
			o_sclk <= 1'h0;
			o_mosi <= d[i];
			#62.5;
			o_sclk <= 1'h1;
			rx = {rx[6:0], line};
			o_rx_byte <= rx;
			o_rx_valid <= lsn && (n - i) % 8 == 0;
			// The valid pulse lasts up to the next clock edge only.
			fork
				#62.5;
				begin
					tick(1);
					o_rx_valid <= 1'h0;
				end
			join
		end
	endtask
	// Returns the clock to idle, then deselects before any new rise.
	task automatic close_frame();
		o_sclk <= cpol;
		tick(4);
		o_cs_n <= 1'h1;
		tick(8);
	endtask
	// Holds only while selected and with the clock low, then wiggles pins.
	task automatic pause();
		o_sclk <= 1'h0;
		tick(5);
		o_hold_n <= 1'h0;
		tick(6);
		repeat (2) begin
			o_sclk <= ~o_sclk;
			o_mosi <= ~o_mosi;
			tick(6);
		end
	endtask
	task automatic unpause();
		o_hold_n <= 1'h1;
		tick(6);
	endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
`include "spi_eeprom_map.vh"
// ****************************************
// Self-checking bench
// ****************************************
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, guard_n, nv_lock;
	logic [1:0] nv_size;
	logic [15:0] seed;
	logic [7:0] d0, d1;
	logic [7:0] expq[$];
	logic [11:0] addrs[3] = '{12'h7ff, 12'hbff, 12'hc00};
	bit ok;
	int fail_count, checks_done;
	wire logic miso, oe, nvs, lock, latch, busy, sel, stby, hact, rxv;
	wire logic sclk, cs_n, mosi, hold_n;
	wire logic [1:0] size;
	wire logic [7:0] rxb;
	spi_eeprom_bus_front_end #(.WRITE_CYCLES(20'h00014)) dut (
		.i_clk_sys(clk), .i_rst(rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
		.i_spi_mosi(mosi), .i_hold_n(hold_n), .i_write_guard_n(guard_n),
		.o_spi_miso(miso), .o_spi_miso_oe(oe), .i_nv_lock_stored(nv_lock),
		.i_nv_size_stored(nv_size), .o_nv_store(nvs),
		.o_status_lock_bit(lock), .o_protect_size(size),
		.o_write_latch_flag(latch), .o_write_busy_flag(busy),
		.o_selected(sel), .o_standby(stby), .o_hold_active(hact));
	spi_master_model m (
		.i_clk_sys(clk), .i_miso(miso), .i_miso_oe(oe), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n), .o_rx_valid(rxv),
		.o_rx_byte(rxb));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Waits, within a bound, for the write cycle to end.
	task automatic wait_idle();
		for (int n = 0; busy !== 1'h0; n++) begin
			if (n > 400) begin
				fail_count++;
				tally_and_finish();
			end
			@(posedge clk);
		end
	endtask
	task automatic cmd(input logic [39:0] d, input int n);
		m.open_frame();
		m.shift(d, n, 1'h0);
		m.close_frame();
	endtask
	// Sends a write, optionally armed, and checks whether it launched.
	task automatic wr(input bit arm, input logic [39:0] d, input int n,
		input bit go);
		if (arm) cmd(`OP_WRITE_ARM, 8);
		cmd(d, n);
		check(busy, go);
		wait_idle();
	endtask
	// Sends an opcode, then notes two expected bytes and reads them.
	task automatic rd(input logic [39:0] d, input int n,
		input logic [7:0] e0, input logic [7:0] e1);
		m.open_frame();
		m.shift(d, n, 1'h0);
		expq.push_back(e0);
		expq.push_back(e1);
		m.shift(40'h0, 16, 1'h1);
		m.close_frame();
	endtask
	// Pauses a write after n bits, then resumes or deselects.
	task automatic held(input logic [31:0] d, input int n, input bit quit,
		input bit go);
		cmd(`OP_WRITE_ARM, 8);
		m.open_frame();
		m.shift(d >> (32 - n), n, 1'h0);
		m.pause();
		check(hact, 1'h1);
		check(oe, 1'h0);
		if (!quit) m.unpause();
		if (!quit) m.shift(d, 32 - n, 1'h0);
		m.close_frame();
		if (quit) m.unpause();
		check(busy, go);
		check(latch, 1'h1);
		wait_idle();
	endtask
	// Compares each byte read with the oldest noted expectation.
	always @(posedge clk) begin
		if (rxv) check(rxb, expq.size() ? expq.pop_front() : 8'hxx);
	end
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, guard_n, nv_lock, nv_size} = 5'h19;
		seed = 16'd31521;
		repeat (2) @(posedge clk);
		m.o_cs_n <= 1'h0;
		repeat (10) @(posedge clk);
		check(stby, 1'h1);
		rst <= 1'h0;
		@(posedge clk);
		m.shift(`OP_WRITE_ARM, 8, 1'h0);
		m.close_frame();
		check(latch, 1'h0);
		check({lock, size}, 3'h1);
		d0 = seed[7:0];
		seed = lfsr(seed);
		d1 = seed[7:0];
		wr(1'h1, {`OP_ARRAY_WRITE, 16'h0010, d0}, 32, 1'h1);
		wr(1'h1, {`OP_ARRAY_WRITE, 16'h0011, d1}, 32, 1'h1);
		rd({`OP_ARRAY_READ, 16'h0010}, 24, d0, d1);
		wr(1'h0, {`OP_ARRAY_WRITE, 16'h0010, ~d0}, 32, 1'h0);
		wr(1'h1, {`OP_ARRAY_WRITE, 16'h0010, ~d0, 1'h1}, 33, 1'h0);
		m.cpol = 1'h1;
		rd(`OP_STATUS_READ, 8, 8'h06, 8'h06);
		m.cpol = 1'h0;
		cmd(`OP_WRITE_DISARM, 8);
		cmd({`OP_WRITE_ARM, 1'h0}, 9);
		check(latch, 1'h0);
		for (int s = 0; s < 4; s++) begin
			wr(1'h1, {`OP_STATUS_WRITE, 4'h0, s[1:0], 2'h0}, 16, 1'h1);
			check(size, s[1:0]);
			for (int k = 0; k < 3; k++) begin
				ok = s == 0 || (s == 1 && addrs[k] < 12'hc00) ||
					(s == 2 && addrs[k] < 12'h800);
				seed = lfsr(seed);
				wr(1'h1, {`OP_ARRAY_WRITE, 4'h0, addrs[k], seed[7:0]}, 32, ok);
			end
		end
		wr(1'h1, {`OP_STATUS_WRITE, 8'h8c}, 16, 1'h1);
		guard_n <= 1'h0;
		wr(1'h1, {`OP_STATUS_WRITE, 8'h00}, 16, 1'h0);
		check({lock, size}, 3'h7);
		guard_n <= 1'h1;
		wr(1'h1, {`OP_STATUS_WRITE, 8'h00}, 16, 1'h1);
		held({`OP_ARRAY_WRITE, 16'h0020, d1}, 20, 1'h0, 1'h1);
		held({`OP_ARRAY_WRITE, 16'h0021, d0}, 32, 1'h1, 1'h1);
		held({`OP_ARRAY_WRITE, 16'h0022, d0}, 20, 1'h1, 1'h0);
		check(8'(expq.size()), 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire

//--- shared/spi_eeprom_map.vh
`ifndef SPI_EEPROM_MAP_VH
`define SPI_EEPROM_MAP_VH
// ****************************************************************
// Instruction codes
// ****************************************************************
`define OP_WRITE_ARM 8'h06
`define OP_WRITE_DISARM 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
// ****************************************************************
// Byte counts at which instructions end, read data start or the count saturates
// ****************************************************************
`define BYTES_ARM 3'h1
`define BYTES_STATUS_WRITE 3'h2
`define BYTES_ADDR_DONE 3'h3
`define BYTES_ARRAY_WRITE 3'h4
`define BYTES_MAX 3'h7
// ****************************************************************
// Status byte layout
// ****************************************************************
`define SR_LOCK 7
`define SR_SIZE_HI 3
`define SR_SIZE_LO 2
`define SR_LATCH 1
`define SR_BUSY 0
// ****************************************************************
// Protected range bounds
// ****************************************************************
`define SIZE_NONE 2'h0
`define SIZE_QUARTER 2'h1
`define SIZE_HALF 2'h2
`define SIZE_WHOLE 2'h3
`define BASE_QUARTER 12'hc00
`define BASE_HALF 12'h800
`define BASE_WHOLE 12'h000
// ****************************************************************
// Timing
// ****************************************************************
`define WRITE_CYCLES_DEF 20'h003e8
`endif

//--- src/spi_byte_store.v
`default_nettype none
// ****************************************************************
// Byte array with registered read data
// ****************************************************************
module spi_byte_store (
	// Clock and reset.
	input wire i_clk_sys,
	input wire i_rst,
	// Write port.
	input wire i_wr_en,
	input wire [11:0] i_wr_addr,
	input wire [7:0] i_wr_data,
	// Read port.
	input wire [11:0] i_rd_addr,
	output reg [7:0] o_rd_data
);

	reg [7:0] mem [0:4095];

	// The array itself is never cleared, as a real array keeps its data.
	always @(posedge i_clk_sys) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	// Read data follow the address one cycle later.
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
		end else begin
			o_rd_data <= mem[i_rd_addr];
		end
	end

endmodule
`default_nettype wire

//--- src/spi_eeprom_bus_front_end.v
// Summary of operation
// - Input bits shift in MSB first.
// - Output bytes launch MSB first on falling edges.
// - Two clock modes, rise samples, fall drives.
// - Reset clears latch and busy flags.
// - Select needs a falling edge first.
// - Standby only when deselected and idle.
// - Hold floats output, freezes bit position.
// - Hold changes only while clock low.
// - Deselect in hold resets protocol logic.
// - Complete write still launches on deselect.
// - Writes need whole multiples of eight.
// - Modifying commands need the latch set.
// - Deselect must follow final bit edge.
// - Final bit per instruction; reads exempt.
// - Size bits pick protected range.
// - Write guard freezes size bits while lock bit set.
// - Output floats while deselected.
// - Locked status refuses status writes while write guard low.
`include "spi_eeprom_map.vh"
`default_nettype none
module spi_eeprom_bus_front_end #(
	parameter [19:0] WRITE_CYCLES = `WRITE_CYCLES_DEF
) (
	// Clock and reset.
	input wire i_clk_sys,
	input wire i_rst,
	// Serial bus pins.
	input wire i_spi_sclk,
	input wire i_spi_cs_n,
	input wire i_spi_mosi,
	input wire i_hold_n,
	input wire i_write_guard_n,
	output reg o_spi_miso,
	output reg o_spi_miso_oe,
	// Nonvolatile backing store.
	input wire i_nv_lock_stored,
	input wire [1:0] i_nv_size_stored,
	output reg o_nv_store,
	// Status bits.
	output reg o_status_lock_bit,
	output reg [1:0] o_protect_size,
	output reg o_write_latch_flag,
	output reg o_write_busy_flag,
	output reg o_selected,
	output reg o_standby,
	output reg o_hold_active
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Tells whether an address lies in the range picked by the size bits.
	function in_protected;
		input [11:0] a;
		input [1:0] size;
		begin
			case (size)
				`SIZE_NONE: in_protected = 1'b0;
				`SIZE_QUARTER: in_protected = (a >= `BASE_QUARTER);
				`SIZE_HALF: in_protected = (a >= `BASE_HALF);
				default: in_protected = (a >= `BASE_WHOLE);
			endcase
		end
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************

	reg sclk_m, sclk_s, sclk_q;
	reg cs_m, cs_s, cs_q;
	reg mosi_m, mosi_s;
	reg hold_m, hold_s;
	reg guard_m, guard_s;

	// Every pin passes two flops; a third copy gives the edges.
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_q <= 1'b0;
			cs_m <= 1'b0;
			cs_s <= 1'b0;
			cs_q <= 1'b0;
			mosi_m <= 1'b0;
			mosi_s <= 1'b0;
			hold_m <= 1'b1;
			hold_s <= 1'b1;
			guard_m <= 1'b1;
			guard_s <= 1'b1;
		end else begin
			sclk_m <= i_spi_sclk;
			sclk_s <= sclk_m;
			sclk_q <= sclk_s;
			cs_m <= i_spi_cs_n;
			cs_s <= cs_m;
			cs_q <= cs_s;
			mosi_m <= i_spi_mosi;
			mosi_s <= mosi_m;
			hold_m <= i_hold_n;
			hold_s <= hold_m;
			guard_m <= i_write_guard_n;
			guard_s <= guard_m;
		end
	end

	// Edges work the same whatever the idle level of the clock.
	wire sclk_rise = sclk_s & ~sclk_q;
	wire sclk_fall = ~sclk_s & sclk_q;
	// A low select seen straight after reset is not an edge.
	wire cs_fall = cs_q & ~cs_s;
	wire cs_rise = ~cs_q & cs_s;

	// ****************************************************************
	// Protocol state
	// ****************************************************************

	reg [2:0] bit_pos;
	reg [2:0] byte_cnt;
	reg [6:0] shift_in;
	reg [7:0] opcode;
	reg [11:0] addr;
	reg [7:0] data_byte;
	reg [19:0] cycle_cnt;
	reg pend_status;
	reg [11:0] pend_addr;
	reg [7:0] pend_data;
	reg mem_we;
	reg nv_loaded;
	reg [7:0] tx_shift;
	wire [7:0] rd_data;

	wire [7:0] next_byte = {shift_in, mosi_s};
	wire byte_done = (bit_pos == 3'h7);
	wire live = o_selected & ~o_hold_active;
	// Status reads and array reads may be ended at any point.
	wire reading = ((opcode == `OP_STATUS_READ) &&
		(byte_cnt >= `BYTES_ARM)) ||
		((opcode == `OP_ARRAY_READ) &&
		(byte_cnt >= `BYTES_ADDR_DONE));
	wire tx_load = live & sclk_fall & reading & (bit_pos == 3'h0);
	// Whole bytes only, so the edge of the final bit was the last one.
	wire whole = (bit_pos == 3'h0);
	wire hw_locked = o_status_lock_bit & ~guard_s;
	wire [7:0] status_byte = {o_status_lock_bit, 3'h0, o_protect_size,
		o_write_latch_flag, o_write_busy_flag};

	// Decisions taken when the master deselects the device.
	wire ex_arm = (opcode == `OP_WRITE_ARM) && whole &&
		(byte_cnt == `BYTES_ARM) && ~o_write_busy_flag;
	wire ex_disarm = (opcode == `OP_WRITE_DISARM) && whole &&
		(byte_cnt == `BYTES_ARM) && ~o_write_busy_flag;
	wire ex_status = (opcode == `OP_STATUS_WRITE) && whole &&
		(byte_cnt == `BYTES_STATUS_WRITE) && o_write_latch_flag &&
		~hw_locked && ~o_write_busy_flag;
	wire ex_array = (opcode == `OP_ARRAY_WRITE) && whole &&
		(byte_cnt >= `BYTES_ARRAY_WRITE) && o_write_latch_flag &&
		~in_protected(addr, o_protect_size) &&
		~o_write_busy_flag;

	// ****************************************************************
	// Select, hold, shifting and write cycle
	// ****************************************************************

	// Select and hold tracking, bit shifting and the timed write cycle.
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_selected <= 1'b0;
			o_hold_active <= 1'b0;
			o_write_latch_flag <= 1'b0;
			o_write_busy_flag <= 1'b0;
			o_status_lock_bit <= 1'b0;
			o_protect_size <= 2'h0;
			o_nv_store <= 1'b0;
			nv_loaded <= 1'b0;
			bit_pos <= 3'h0;
			byte_cnt <= 3'h0;
			shift_in <= 7'h00;
			opcode <= 8'h00;
			addr <= 12'h000;
			data_byte <= 8'h00;
			cycle_cnt <= 20'h00000;
			pend_status <= 1'b0;
			pend_addr <= 12'h000;
			pend_data <= 8'h00;
			mem_we <= 1'b0;
		end else begin
			o_nv_store <= 1'b0;
			mem_we <= 1'b0;
			// Stored protection bits come back from the backing store.
			if (!nv_loaded) begin
				nv_loaded <= 1'b1;
				o_status_lock_bit <= i_nv_lock_stored;
				o_protect_size <= i_nv_size_stored;
			end
			// Timed write cycle; the latch drops when it completes.
			if (o_write_busy_flag) begin
				if (cycle_cnt == WRITE_CYCLES - 20'h00001) begin
					o_write_busy_flag <= 1'b0;
					o_write_latch_flag <= 1'b0;
					cycle_cnt <= 20'h00000;
					if (pend_status) begin
						o_status_lock_bit <= pend_data[`SR_LOCK];
						o_protect_size <= {pend_data[`SR_SIZE_HI],
							pend_data[`SR_SIZE_LO]};
						o_nv_store <= 1'b1;
					end else begin
						mem_we <= 1'b1;
					end
				end else begin
					cycle_cnt <= cycle_cnt + 20'h00001;
				end
			end
			if (cs_fall) begin
				// A fresh selection starts with a clean shifter.
				o_selected <= 1'b1;
				o_hold_active <= 1'b0;
				bit_pos <= 3'h0;
				byte_cnt <= 3'h0;
				opcode <= 8'h00;
			end else if (cs_rise && o_selected) begin
				// Deselect, in or out of hold, ends the command.
				o_selected <= 1'b0;
				o_hold_active <= 1'b0;
				bit_pos <= 3'h0;
				byte_cnt <= 3'h0;
				opcode <= 8'h00;
				if (ex_arm) begin
					o_write_latch_flag <= 1'b1;
				end
				if (ex_disarm) begin
					o_write_latch_flag <= 1'b0;
				end
				if (ex_status || ex_array) begin
					o_write_busy_flag <= 1'b1;
					cycle_cnt <= 20'h00000;
					pend_status <= ex_status;
					pend_addr <= addr;
					pend_data <= data_byte;
				end
			end else if (o_selected) begin
				// Hold moves only while the clock is low.
				if (!sclk_s) begin
					o_hold_active <= ~hold_s;
				end
				// Clock edges count only outside hold.
				if (sclk_rise && !o_hold_active) begin
					shift_in <= next_byte[6:0];
					bit_pos <= bit_pos + 3'h1;
					if (byte_done) begin
						if (byte_cnt != `BYTES_MAX) begin
							byte_cnt <= byte_cnt + 3'h1;
						end
						case (byte_cnt)
							3'h0: begin
								opcode <= next_byte;
							end
							3'h1: begin
								addr[11:8] <= next_byte[3:0];
								data_byte <= next_byte;
							end
							3'h2: begin
								addr[7:0] <= next_byte;
							end
							3'h3: begin
								data_byte <= next_byte;
							end
							default: begin
								data_byte <= data_byte;
							end
						endcase
					end
				end
				// Array reads step to the next byte as each one loads.
				if (tx_load && (opcode == `OP_ARRAY_READ)) begin
					addr <= addr + 12'h001;
				end
			end
		end
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************

	// Output bytes leave MSB first; hold and deselect float the pin.
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_spi_miso <= 1'b0;
			o_spi_miso_oe <= 1'b0;
			tx_shift <= 8'h00;
		end else if (!o_selected || cs_rise) begin
			o_spi_miso_oe <= 1'b0;
			tx_shift <= 8'h00;
		end else if (o_hold_active) begin
			o_spi_miso_oe <= 1'b0;
		end else if (tx_load) begin
			// First bit of each byte goes out on its falling edge.
			if (opcode == `OP_STATUS_READ) begin
				o_spi_miso <= status_byte[7];
				tx_shift <= {status_byte[6:0], 1'b0};
			end else begin
				o_spi_miso <= rd_data[7];
				tx_shift <= {rd_data[6:0], 1'b0};
			end
			o_spi_miso_oe <= 1'b1;
		end else if (sclk_fall && reading) begin
			o_spi_miso <= tx_shift[7];
			tx_shift <= {tx_shift[6:0], 1'b0};
			o_spi_miso_oe <= 1'b1;
		end else if (!reading) begin
			o_spi_miso_oe <= 1'b0;
		end
	end

	// ****************************************************************
	// Power mode
	// ****************************************************************

	// Standby only once deselected with no write cycle running.
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_standby <= 1'b1;
		end else begin
			o_standby <= ~o_selected & ~o_write_busy_flag;
		end
	end

	// ****************************************************************
	// Array storage
	// ****************************************************************

	spi_byte_store u_store (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_wr_en(mem_we),
		.i_wr_addr(pend_addr),
		.i_wr_data(pend_data),
		.i_rd_addr(addr),
		.o_rd_data(rd_data)
	);

endmodule
`default_nettype wire
